// *** lsrc_defines.vh ***
// Purpose: constants for the load switch / regulator configuration bank
// Assumes: byte-wide registers reached over a plain address port
// Notes: voltages are held in millivolts
`ifndef LSRC_DEFINES_VH
`define LSRC_DEFINES_VH
`define LSRC_ADDR_W 8
`define LSRC_OFF_CFG1 8'h14
`define LSRC_OFF_CFG2 8'h15
`define LSRC_OFF_UNLOCK 8'h20
`define LSRC_OFF_STATUS 8'h21
`define LSRC_UNLOCK_XOR 8'h7D
`define LSRC_SEL_BIT 5
`define LSRC_CODE_MSB 4
`define LSRC_CODE_LSB 0
`define LSRC_RSV_MSB 7
`define LSRC_RSV_LSB 6
`define LSRC_CFG1_RESET 8'h06
`define LSRC_CFG2_RESET 8'h15
`define LSRC_MV_W 12
`define LSRC_MV_MIN 12'h5DC
`define LSRC_MV_MAX 12'hCE4
`endif

// *** lsrc_voltage_lut.v ***
// Purpose: map a 5-bit regulator voltage code to millivolts
// Assumes: code is stable; purely combinational lookup
// Notes: non-linear table, 1500 mV at 0 up to 3300 mV at all ones
`timescale 1ns/1ns
`include "lsrc_defines.vh"
module lsrc_voltage_lut (
	input wire [4:0] code,
	output reg [`LSRC_MV_W-1:0] millivolts
);
	// table lookup; lower half has uneven steps, upper half 50 mV steps
	always @* begin
		case (code)
		5'h00: millivolts = `LSRC_MV_MIN;
		5'h01: millivolts = 12'd1550;
		5'h02: millivolts = 12'd1600;
		5'h03: millivolts = 12'd1650;
		5'h04: millivolts = 12'd1700;
		5'h05: millivolts = 12'd1750;
		5'h06: millivolts = 12'd1800;
		5'h07: millivolts = 12'd1850;
		5'h08: millivolts = 12'd1900;
		5'h09: millivolts = 12'd2000;
		5'h0A: millivolts = 12'd2100;
		5'h0B: millivolts = 12'd2200;
		5'h0C: millivolts = 12'd2300;
		5'h0D: millivolts = 12'd2400;
		5'h0E: millivolts = 12'd2450;
		5'h0F: millivolts = 12'd2500;
		5'h1F: millivolts = `LSRC_MV_MAX;
		// codes 0x10..0x1E climb from 2550 mV in 50 mV steps
		default: millivolts = 12'd2550 + {4'h0, 3'h0, code[3:0], 1'b0} * 12'd25;
		endcase
	end
endmodule // lsrc_voltage_lut

// *** lsrc_config_bank.v ***
// Purpose: two switch/regulator configuration registers with write unlock
// Assumes: register port strobes are one cycle, synchronous to clk
// Notes: reset values are variant dependent, so they are parameters
//
// Behaviour
// - first register bits 7:6 read zero
// - second register bits 7:6 read zero
// - first bit 5 selects switch or regulator
// - second bit 5 selects switch or regulator
// - first code bits 4:0 set regulator voltage
// - second code uses same voltage lookup
// - second register lives at 0x15
// - writes need password unlock first; here any write to 0x20 unlocks, the data is not checked
// - first register lives at 0x14
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`include "lsrc_defines.vh"
module lsrc_config_bank #(
	parameter [7:0] CFG1_RESET = `LSRC_CFG1_RESET,
	parameter [7:0] CFG2_RESET = `LSRC_CFG2_RESET
) (
	input wire clk,
	input wire arst_n,
	input wire [`LSRC_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	output wire switch1_regulator_select,
	output wire switch2_regulator_select,
	output wire [4:0] regulator3_voltage_code,
	output wire [4:0] regulator4_voltage_code,
	output wire [`LSRC_MV_W-1:0] regulator3_millivolts,
	output wire [`LSRC_MV_W-1:0] regulator4_millivolts,
	output wire first_load_switch_mode,
	output wire second_load_switch_mode
);
	// stored writable fields, bits 5:0 only; reserved bits have no storage
	reg [5:0] cfg1; // select plus code of first pass device
	reg [5:0] cfg2; // select plus code of second pass device
	reg unlocked; // armed by any write to the unlock address, spent by next protected write
	reg rejected; // sticky: a protected write was dropped
	wire [`LSRC_MV_W-1:0] mv3; // lookup result for first code
	wire [`LSRC_MV_W-1:0] mv4; // lookup result for second code

	// address decode used by the write path; the read path decodes with its own case
	function [1:0] lsrc_hit;
		input [`LSRC_ADDR_W-1:0] a;
		begin
			lsrc_hit = {a == `LSRC_OFF_CFG2, a == `LSRC_OFF_CFG1};
		end
	endfunction

	wire [1:0] wr_hit = reg_write ? lsrc_hit(reg_addr) : 2'b00;
	// a protected write counts only while the unlock is armed
	wire wr_ok = unlocked & (|wr_hit);

	// unlock: any write to the unlock address arms it, the written data is not checked;
	// one unlock allows exactly one protected write, which blunts runaway code
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			unlocked <= 1'b0;
			rejected <= 1'b0;
		end else if (reg_write) begin
			if (reg_addr == `LSRC_OFF_UNLOCK) begin
				unlocked <= 1'b1;
			end else if (|wr_hit) begin
				unlocked <= 1'b0; // any protected write spends it
				if (!unlocked) begin
					rejected <= 1'b1;
				end
			end else if (reg_addr == `LSRC_OFF_STATUS) begin
				rejected <= 1'b0; // software clears the sticky flag
			end
		end
	end

	// configuration storage; writes to bits 7:6 are dropped
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg1 <= CFG1_RESET[5:0];
			cfg2 <= CFG2_RESET[5:0];
		end else if (wr_ok) begin
			if (wr_hit[0]) begin
				cfg1 <= reg_wdata[`LSRC_SEL_BIT:0];
			end
			if (wr_hit[1]) begin
				cfg2 <= reg_wdata[`LSRC_SEL_BIT:0];
			end
		end
	end

	// read data stands in the cycle after the strobe; unmapped reads zero
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			case (reg_addr)
			`LSRC_OFF_CFG1: reg_rdata <= {2'b00, cfg1};
			`LSRC_OFF_CFG2: reg_rdata <= {2'b00, cfg2};
			`LSRC_OFF_STATUS: reg_rdata <= {6'h00, rejected, unlocked};
			default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// voltage lookups, one per pass device
	lsrc_voltage_lut u_lut3 (
		.code(cfg1[`LSRC_CODE_MSB:`LSRC_CODE_LSB]),
		.millivolts(mv3)
	);
	lsrc_voltage_lut u_lut4 (
		.code(cfg2[`LSRC_CODE_MSB:`LSRC_CODE_LSB]),
		.millivolts(mv4)
	);

	assign switch1_regulator_select = cfg1[`LSRC_SEL_BIT];
	assign switch2_regulator_select = cfg2[`LSRC_SEL_BIT];
	assign regulator3_voltage_code = cfg1[4:0];
	assign regulator4_voltage_code = cfg2[4:0];
	// in switch mode the code is kept but the voltage target reads zero
	assign regulator3_millivolts = cfg1[`LSRC_SEL_BIT] ? mv3 : {`LSRC_MV_W{1'b0}};
	assign regulator4_millivolts = cfg2[`LSRC_SEL_BIT] ? mv4 : {`LSRC_MV_W{1'b0}};
	assign first_load_switch_mode = ~cfg1[`LSRC_SEL_BIT];
	assign second_load_switch_mode = ~cfg2[`LSRC_SEL_BIT];
endmodule // lsrc_config_bank

// *** lsrc_props.sv ***
// Purpose: port checks for the config bank
// Assumes: one clock, async active-low reset
// Notes: unlock state is rebuilt here from the bus
`timescale 1ns/1ns
module lsrc_props (
	input wire clk,
	input wire arst_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_rdata,
	input wire switch1_regulator_select,
	input wire [4:0] regulator3_voltage_code,
	input wire [11:0] regulator3_millivolts
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	reg unl; // unlock seen and not yet spent
	wire [5:0] cfg1 = {switch1_regulator_select, regulator3_voltage_code};
	// any write to a protected register spends the unlock
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			unl <= 1'b0;
		else if (reg_write)
			unl <= (reg_addr == 8'h20) | (unl & reg_addr != 8'h14 & reg_addr != 8'h15);
	end
	chk_rsv_zero: assert property (reg_rdata[7:6] == 2'h0)
		else $error("reserved bits read set");
	chk_rd_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
		else $error("read data outside slot");
	chk_rd_cfg: assert property (reg_read && reg_addr == 8'h14 |=> reg_rdata == {2'h0, $past(cfg1)})
		else $error("first register read wrong");
	chk_lock_hold: assert property (reg_write && !unl && reg_addr == 8'h14 |=> $stable(cfg1))
		else $error("locked write landed");
	chk_unlock_take: assert property (reg_write && unl && reg_addr == 8'h14 |=> cfg1 == $past(reg_wdata[5:0]))
		else $error("unlocked write lost");
	chk_mv_off: assert property (!switch1_regulator_select |-> regulator3_millivolts == 12'h000)
		else $error("switch mode gives voltage");
	chk_mv_range: assert property (switch1_regulator_select |-> regulator3_millivolts inside {[12'h5DC:12'hCE4]})
		else $error("voltage out of range");
	chk_mv_top: assert property (switch1_regulator_select && regulator3_voltage_code == 5'h1F |-> regulator3_millivolts == 12'hCE4)
		else $error("top code not 3300");
	cover property (reg_write && unl && reg_addr == 8'h14);
	cover property (reg_write && !unl && reg_addr == 8'h14);
	cover property (reg_read && reg_addr == 8'h14);
endmodule // lsrc_props

// *** lsrc_config_bank_bench.sv ***
// Purpose: directed register tests for the config bank
// Assumes: default reset parameters 0x06 and 0x15
// Notes: no waits on handshakes, the slave never stalls
`timescale 1ns/1ns
module lsrc_config_bank_bench;
	reg clk = 1'b0, arst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
	reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	wire [7:0] reg_rdata;
	wire switch1_regulator_select, switch2_regulator_select;
	wire first_load_switch_mode, second_load_switch_mode;
	wire [4:0] regulator3_voltage_code, regulator4_voltage_code;
	wire [11:0] regulator3_millivolts, regulator4_millivolts;
	integer mismatches = 0, n_checks = 0;
	lsrc_config_bank u_dut (
		.clk(clk),
		.arst_n(arst_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_rdata(reg_rdata),
		.switch1_regulator_select(switch1_regulator_select),
		.switch2_regulator_select(switch2_regulator_select),
		.regulator3_voltage_code(regulator3_voltage_code),
		.regulator4_voltage_code(regulator4_voltage_code),
		.regulator3_millivolts(regulator3_millivolts),
		.regulator4_millivolts(regulator4_millivolts),
		.first_load_switch_mode(first_load_switch_mode),
		.second_load_switch_mode(second_load_switch_mode)
	);
	always #2 clk = ~clk; // 250 MHz
	task cmp(input [11:0] got, input [11:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe; settle before returning
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		#1;
	endtask
	task uw(input [7:0] a, input [7:0] d);
		wr(8'h20, 8'h00);
		wr(a, d);
	endtask
	// data stands only in the cycle after the strobe
	task rd(input [7:0] a, input [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 cmp(reg_rdata, exp);
	endtask
	task finish_test;
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		rd(8'h14, 8'h06);
		rd(8'h15, 8'h15);
		cmp(first_load_switch_mode, 1'b1);
		wr(8'h14, 8'hFF);
		rd(8'h14, 8'h06);
		rd(8'h21, 8'h02);
		wr(8'h21, 8'h00);
		rd(8'h21, 8'h00);
		wr(8'h20, 8'h00);
		rd(8'h21, 8'h01);
		wr(8'h14, 8'hFF);
		rd(8'h14, 8'h3F);
		rd(8'h21, 8'h00);
		cmp(regulator3_millivolts, 12'hCE4);
		cmp(switch1_regulator_select, 1'b1);
		cmp(regulator3_voltage_code, 5'h1F);
		cmp(first_load_switch_mode, 1'b0);
		uw(8'h14, 8'h20);
		cmp(regulator3_millivolts, 12'h5DC);
		uw(8'h15, 8'h35);
		cmp(regulator4_millivolts, 12'hAF0);
		cmp(switch2_regulator_select, 1'b1);
		cmp(regulator4_voltage_code, 5'h15);
		cmp(second_load_switch_mode, 1'b0);
		uw(8'h15, 8'hDF);
		rd(8'h15, 8'h1F);
		cmp(regulator4_millivolts, 12'h000);
		cmp(regulator4_voltage_code, 5'h1F);
		cmp(second_load_switch_mode, 1'b1);
		rd(8'h30, 8'h00);
		finish_test;
	end
	// hang guard
	initial begin
		repeat (500) @(posedge clk);
		mismatches = mismatches + 1;
		finish_test;
	end
endmodule // lsrc_config_bank_bench
bind lsrc_config_bank lsrc_props u_props (
	.clk(clk),
	.arst_n(arst_n),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_write(reg_write),
	.reg_read(reg_read),
	.reg_rdata(reg_rdata),
	.switch1_regulator_select(switch1_regulator_select),
	.regulator3_voltage_code(regulator3_voltage_code),
	.regulator3_millivolts(regulator3_millivolts)
);
